// [dmacs_top.sv]
// six-channel dma sequencer: apb registers, transfer engine, counting and indexing
// the engine holds mem_req_o until mem_ack_i; assumes sync events are one-cycle pulses
`timescale 1ns/1ps
module dmacs_top
   import dmacs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // memory port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i,
   // sync events, bit n is sync code n+1
   input wire logic [13:0] sync_evt_i,
   // serial port interrupts
   input wire logic port2_receive_irq_i,
   input wire logic port2_transmit_irq_i,
   input wire logic port1_receive_irq_i,
   input wire logic port1_transmit_irq_i,
   // cpu interrupt lines
   output logic cpu_irq6_o,
   output logic cpu_irq7_o,
   output logic cpu_irq10_o,
   output logic cpu_irq11_o,
   output logic channel4_irq_o,
   output logic channel5_irq_o
);
   typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} dmacs_eng_t;
   typedef struct packed {
      logic hit;
      logic glob;
      logic [2:0] ch;
      logic [5:0] off;
   } dmacs_dec_t;
   typedef struct packed {
      logic [15:0] prio_en;
      logic [1:0][15:0] estep;
      logic [1:0][15:0] fstep;
      logic [5:0][15:0] src;
      logic [5:0][15:0] dst;
      logic [5:0][15:0] ecnt;
      logic [5:0][15:0] len;
      logic [5:0][7:0] fcnt;
      logic [5:0][3:0] sync;
      logic [5:0][15:0] mode;
      logic [5:0][15:0] rsrc;
      logic [5:0][15:0] rdst;
      logic [5:0][15:0] recnt;
      logic [5:0][7:0] rfcnt;
      logic [5:0] pend;
      dmacs_eng_t eng;
      logic [2:0] ch;
      logic hi_half;
      logic lastf;
      logic blk_end;
      logic irq_due;
      logic [15:0] data;
      logic [5:0] chan_irq;
      logic [31:0] prdata;
      logic pslverr;
   } dmacs_st_t;

   dmacs_st_t st_ff, nxt_st;
   dmacs_link_if link();

   function automatic dmacs_dec_t dmacs_decode(input logic [15:0] a);
      dmacs_dec_t d;
      d.glob = (a[15:6] == 10'h000);
      d.ch = 3'(a[8:6] - 3'h1);
      d.off = a[5:0];
      d.hit = (a[1:0] == 2'h0) && (d.glob ? (a[5:0] <= OFS_STATUS[5:0])
         : ((a[15:9] == 7'h00) && (a[8:6] != 3'h7) && (a[5:0] <= CH_RFCNT)));
      return d;
   endfunction

   // selected address step per transfer
   function automatic logic [15:0] dmacs_step(input logic [2:0] sel, input logic last, input dmacs_st_t s);
      logic [15:0] v;
      unique case (sel)
         IDX_INC: v = 16'h0001;
         IDX_DEC: v = 16'hffff;
         IDX_STEP0: v = last ? s.fstep[0] : s.estep[0];
         IDX_STEP1: v = last ? s.fstep[1] : s.estep[1];
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // trigger for one channel's sync code
   function automatic logic dmacs_sync_hit(input logic [3:0] code, input logic [13:0] evt);
      logic h;
      h = 1'b0;
      if (code != SYNC_NONE && code != SYNC_RSVD) h = evt[4'(code - 4'h1)];
      return h;
   endfunction

   function automatic logic [31:0] dmacs_read(input dmacs_dec_t d, input dmacs_st_t s);
      logic [31:0] r;
      logic [5:0] busy;
      busy = '0;
      if (s.eng != ENG_IDLE) busy[s.ch] = 1'b1;
      r = 32'h0000_0000;
      if (d.glob) begin
         unique case (d.off)
            OFS_PRIO[5:0]: r[15:0] = s.prio_en;
            OFS_ESTEP0[5:0]: r[15:0] = s.estep[0];
            OFS_ESTEP1[5:0]: r[15:0] = s.estep[1];
            OFS_FSTEP0[5:0]: r[15:0] = s.fstep[0];
            OFS_FSTEP1[5:0]: r[15:0] = s.fstep[1];
            OFS_STATUS[5:0]: r[15:0] = {2'h0, s.pend, 2'h0, busy};
            default: r = 32'h0000_0000;
         endcase
      end else begin
         unique case (d.off)
            CH_SRC: r[15:0] = s.src[d.ch];
            CH_DST: r[15:0] = s.dst[d.ch];
            CH_ECNT: r[15:0] = s.ecnt[d.ch];
            CH_SYNCF: r[15:0] = {s.sync[d.ch], 4'h0, s.fcnt[d.ch]};
            CH_MODE: r[15:0] = s.mode[d.ch];
            CH_RSRC: r[15:0] = s.rsrc[d.ch];
            CH_RDST: r[15:0] = s.rdst[d.ch];
            CH_RECNT: r[15:0] = s.recnt[d.ch];
            CH_RFCNT: r[15:0] = {8'h00, s.rfcnt[d.ch]};
            default: r = 32'h0000_0000;
         endcase
      end
      return r;
   endfunction

   // current-channel views
   logic [15:0] cur_ecnt;
   logic [7:0] cur_fcnt;
   logic [15:0] cur_mode;
   logic lasthalf;
   assign cur_ecnt = st_ff.ecnt[st_ff.ch];
   assign cur_fcnt = st_ff.fcnt[st_ff.ch];
   assign cur_mode = st_ff.mode[st_ff.ch];
   assign lasthalf = !cur_mode[MODE_DWORD] || st_ff.hi_half;

   always_comb begin
      dmacs_dec_t dec;
      logic [2:0] gidx;
      logic [2:0] rs;
      logic [2:0] c;
      logic fin;
      logic [15:0] new_ecnt;
      logic frame_end;
      logic half_buf;
      dec = dmacs_decode(paddr_i);
      gidx = 3'h0;
      c = st_ff.ch;
      rs = st_ff.prio_en[PE_SET_SEL] ? c : 3'h0;
      fin = lasthalf && (cur_ecnt == 16'h0000);
      new_ecnt = cur_ecnt;
      frame_end = 1'b0;
      half_buf = 1'b0;
      nxt_st = st_ff;
      nxt_st.chan_irq = '0;
      link.take = 1'b0;
      link.high = st_ff.prio_en[PE_PRIO_LSB +: 6];
      for (int i = 0; i < NUM_CH; i++) begin
         // enabled and, if synchronized, triggered
         link.req[i] = st_ff.prio_en[i] && (st_ff.sync[i] == SYNC_NONE || st_ff.pend[i]);
         if (link.grant[i]) gidx = 3'(i);
      end
      unique case (st_ff.eng)
         ENG_IDLE: begin
            if (link.grant != '0) begin
               link.take = 1'b1;
               nxt_st.ch = gidx;
               nxt_st.hi_half = 1'b0;
               nxt_st.pend[gidx] = 1'b0;
               nxt_st.eng = ENG_READ;
            end
         end
         ENG_READ: begin
            if (mem_ack_i) begin
               nxt_st.data = mem_rdata_i;
               nxt_st.lastf = fin;
               nxt_st.src[c] = 16'(st_ff.src[c] + dmacs_step(cur_mode[MODE_SIDX_LSB +: 3], fin, st_ff));
               nxt_st.blk_end = fin && (cur_fcnt == 8'h00);
               if (lasthalf) begin
                  if (cur_ecnt != 16'h0000) begin
                     new_ecnt = 16'(cur_ecnt - 16'h0001);
                  end else if (cur_fcnt != 8'h00) begin
                     nxt_st.fcnt[c] = 8'(cur_fcnt - 8'h01);
                     new_ecnt = st_ff.len[c];
                     frame_end = 1'b1;
                  end
                  nxt_st.ecnt[c] = new_ecnt;
                  half_buf = (cur_ecnt != 16'h0000) && (new_ecnt == {1'b0, st_ff.len[c][15:1]});
               end
               // autobuffer half/full, multiframe frame/block
               nxt_st.irq_due = cur_mode[MODE_IEN] && (nxt_st.blk_end
                  || (cur_mode[MODE_TIMING] && (cur_mode[MODE_ABU] ? half_buf : frame_end)));
               nxt_st.eng = ENG_WRITE;
            end
         end
         ENG_WRITE: begin
            if (mem_ack_i) begin
               nxt_st.dst[c] = 16'(st_ff.dst[c] + dmacs_step(cur_mode[MODE_DIDX_LSB +: 3], st_ff.lastf, st_ff));
               nxt_st.chan_irq[c] = st_ff.irq_due;
               if (st_ff.blk_end) begin
                  if (cur_mode[MODE_AUTO]) begin
                     nxt_st.src[c] = st_ff.rsrc[rs];
                     nxt_st.dst[c] = st_ff.rdst[rs];
                     nxt_st.ecnt[c] = st_ff.recnt[rs];
                     nxt_st.len[c] = st_ff.recnt[rs];
                     nxt_st.fcnt[c] = st_ff.rfcnt[rs];
                  end else begin
                     nxt_st.prio_en[c] = 1'b0;
                  end
               end
               nxt_st.blk_end = 1'b0;
               nxt_st.irq_due = 1'b0;
               nxt_st.hi_half = !lasthalf;
               nxt_st.eng = lasthalf ? ENG_IDLE : ENG_READ;
            end
         end
      endcase
      // an event in the cycle of its clear is kept
      for (int i = 0; i < NUM_CH; i++) begin
         if (dmacs_sync_hit(st_ff.sync[i], sync_evt_i)) nxt_st.pend[i] = 1'b1;
      end
      // apb: read data captured in setup, write taken in access
      if (psel_i && !penable_i) begin
         nxt_st.prdata = dec.hit ? dmacs_read(dec, st_ff) : 32'h0000_0000;
         nxt_st.pslverr = !dec.hit;
      end
      if (psel_i && penable_i && pwrite_i && dec.hit) begin
         if (dec.glob) begin
            unique case (dec.off)
               OFS_PRIO[5:0]: nxt_st.prio_en = pwdata_i[15:0];
               OFS_ESTEP0[5:0]: nxt_st.estep[0] = pwdata_i[15:0];
               OFS_ESTEP1[5:0]: nxt_st.estep[1] = pwdata_i[15:0];
               OFS_FSTEP0[5:0]: nxt_st.fstep[0] = pwdata_i[15:0];
               OFS_FSTEP1[5:0]: nxt_st.fstep[1] = pwdata_i[15:0];
               default: nxt_st.pslverr = st_ff.pslverr;
            endcase
         end else begin
            unique case (dec.off)
               CH_SRC: nxt_st.src[dec.ch] = pwdata_i[15:0];
               CH_DST: nxt_st.dst[dec.ch] = pwdata_i[15:0];
               CH_ECNT: begin
                  nxt_st.ecnt[dec.ch] = pwdata_i[15:0];
                  nxt_st.len[dec.ch] = pwdata_i[15:0];
               end
               CH_SYNCF: begin
                  nxt_st.sync[dec.ch] = pwdata_i[SYNC_LSB +: 4];
                  nxt_st.fcnt[dec.ch] = pwdata_i[7:0];
               end
               CH_MODE: nxt_st.mode[dec.ch] = pwdata_i[15:0];
               // reload set touches no working register
               CH_RSRC: nxt_st.rsrc[dec.ch] = pwdata_i[15:0];
               CH_RDST: nxt_st.rdst[dec.ch] = pwdata_i[15:0];
               CH_RECNT: nxt_st.recnt[dec.ch] = pwdata_i[15:0];
               CH_RFCNT: nxt_st.rfcnt[dec.ch] = pwdata_i[7:0];
               default: nxt_st.pslverr = st_ff.pslverr;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_ff <= '0;
         st_ff.prio_en <= PRIO_RST;
         st_ff.eng <= ENG_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   dmacs_arbiter u_arb (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .link(link.arb)
   );
   dmacs_irq_router u_rtr (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .link(link.rtr)
   );

   assign link.chan_irq = st_ff.chan_irq;
   assign link.port_irq = {port1_transmit_irq_i, port1_receive_irq_i, port2_transmit_irq_i, port2_receive_irq_i};
   assign link.route = st_ff.prio_en[PE_ROUTE_LSB +: 2];
   assign prdata_o = st_ff.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = st_ff.pslverr;
   assign mem_req_o = (st_ff.eng != ENG_IDLE);
   assign mem_we_o = (st_ff.eng == ENG_WRITE);
   assign mem_addr_o = (st_ff.eng == ENG_WRITE) ? st_ff.dst[st_ff.ch] : st_ff.src[st_ff.ch];
   assign mem_wdata_o = st_ff.data;
   assign cpu_irq6_o = link.line[0];
   assign cpu_irq7_o = link.line[1];
   assign cpu_irq10_o = link.line[2];
   assign cpu_irq11_o = link.line[3];
   assign channel4_irq_o = st_ff.chan_irq[4];
   assign channel5_irq_o = st_ff.chan_irq[5];

   logic [2:0] rs_now;
   logic wr_done;
   assign rs_now = st_ff.prio_en[PE_SET_SEL] ? st_ff.ch : 3'h0;
   assign wr_done = (st_ff.eng == ENG_WRITE) && mem_ack_i;
   // per channel: sync condition met, no sync code or an event pending
   logic [5:0] sync_ok;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         sync_ok[i] = (st_ff.sync[i] == SYNC_NONE) || st_ff.pend[i];
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   property p_reload;
      (wr_done && st_ff.blk_end && cur_mode[MODE_AUTO])
         |=> (st_ff.src[st_ff.ch] == $past(st_ff.rsrc[rs_now])) && (cur_ecnt == $past(st_ff.recnt[rs_now]));
   endproperty
   a_reload: assert property (p_reload) else $error("auto reload did not load reload set");
   property p_frame_dec;
      (st_ff.eng == ENG_READ && mem_ack_i && lasthalf && cur_ecnt == 16'h0000 && cur_fcnt != 8'h00)
         |=> (cur_fcnt == 8'($past(cur_fcnt) - 8'h01)) && (st_ff.eng == ENG_WRITE);
   endproperty
   a_frame_dec: assert property (p_frame_dec) else $error("frame count not decremented at read");
   property p_elem_dec;
      (st_ff.eng == ENG_READ && mem_ack_i && lasthalf && cur_ecnt != 16'h0000)
         |=> (cur_ecnt == 16'($past(cur_ecnt) - 16'h0001));
   endproperty
   a_elem_dec: assert property (p_elem_dec) else $error("element count not decremented");
   property p_no_irq;
      (st_ff.chan_irq != '0) |-> $past(cur_mode[MODE_IEN]) && $past(wr_done);
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("interrupt while interrupts disabled");
   sequence s_lo_half_done;
      wr_done && cur_mode[MODE_DWORD] && !st_ff.hi_half;
   endsequence
   sequence s_hi_half_read;
      (st_ff.eng == ENG_READ) && st_ff.hi_half && !link.take;
   endsequence
   property p_dword;
      s_lo_half_done |=> s_hi_half_read;
   endproperty
   a_dword: assert property (p_dword) else $error("second half of doubleword not started");
   property p_sync_gate;
      link.take |-> ((link.grant & ~sync_ok) == '0);
   endproperty
   a_sync_gate: assert property (p_sync_gate) else $error("synchronized channel read without event");
endmodule

// [dmacs_pkg.sv]
// constants, register map and field layout of the six-channel dma sequencer
// assumes a 32-bit apb slave port and 16-bit on-chip memory words
package dmacs_pkg;
   localparam int NUM_CH = 6;
   // global register byte offsets
   localparam logic [15:0] OFS_PRIO = 16'h0000;
   localparam logic [15:0] OFS_ESTEP0 = 16'h0004;
   localparam logic [15:0] OFS_ESTEP1 = 16'h0008;
   localparam logic [15:0] OFS_FSTEP0 = 16'h000c;
   localparam logic [15:0] OFS_FSTEP1 = 16'h0010;
   localparam logic [15:0] OFS_STATUS = 16'h0014;
   // per-channel block at 0x40 * (ch + 1), offsets inside it
   localparam logic [5:0] CH_SRC = 6'h00;
   localparam logic [5:0] CH_DST = 6'h04;
   localparam logic [5:0] CH_ECNT = 6'h08;
   localparam logic [5:0] CH_SYNCF = 6'h0c;
   localparam logic [5:0] CH_MODE = 6'h10;
   localparam logic [5:0] CH_RSRC = 6'h14;
   localparam logic [5:0] CH_RDST = 6'h18;
   localparam logic [5:0] CH_RECNT = 6'h1c;
   localparam logic [5:0] CH_RFCNT = 6'h20;
   // priority/enable register fields
   localparam int PE_SET_SEL = 14;
   localparam int PE_PRIO_LSB = 8;
   localparam int PE_ROUTE_LSB = 6;
   localparam logic [15:0] PRIO_RST = 16'h0000;
   // mode control fields
   localparam int MODE_AUTO = 15;
   localparam int MODE_IEN = 14;
   localparam int MODE_TIMING = 13;
   localparam int MODE_ABU = 12;
   localparam int MODE_SIDX_LSB = 8;
   localparam int MODE_DIDX_LSB = 2;
   localparam int MODE_DWORD = 0;
   localparam int SYNC_LSB = 12;
   // index select codes
   localparam logic [2:0] IDX_INC = 3'h1;
   localparam logic [2:0] IDX_DEC = 3'h2;
   localparam logic [2:0] IDX_STEP0 = 3'h3;
   localparam logic [2:0] IDX_STEP1 = 3'h4;
   // interrupt routing codes
   localparam logic [1:0] ROUTE_PORTS = 2'h0;
   localparam logic [1:0] ROUTE_PART = 2'h1;
   localparam logic [1:0] ROUTE_ALL = 2'h2;
   localparam logic [3:0] SYNC_NONE = 4'h0;
   localparam logic [3:0] SYNC_RSVD = 4'hf;
endpackage

// [dmacs_link_if.sv]
// carrier between the sequencer core, its arbiter and its interrupt router
// assumes all parties run on the same clock
`timescale 1ns/1ps
interface dmacs_link_if;
   logic [5:0] req;
   logic [5:0] high;
   logic [5:0] grant;
   logic take;
   logic [5:0] chan_irq;
   logic [3:0] port_irq;
   logic [1:0] route;
   logic [3:0] line;
   modport arb(input req, input high, input take, output grant);
   modport rtr(input chan_irq, input port_irq, input route, output line);
   modport eng(output req, output high, output take, input grant, output chan_irq, output port_irq, output route,
      input line);
endinterface

// [dmacs_arbiter.sv]
// two-group round-robin channel arbiter
// assumes take is raised only in a cycle that shows a grant
`timescale 1ns/1ps
module dmacs_arbiter
   import dmacs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // requests and grant
   dmacs_link_if.arb link
);
   typedef struct packed {
      logic [2:0] last_hi;
      logic [2:0] last_lo;
   } dmacs_arb_st_t;
   dmacs_arb_st_t st_ff, nxt_st;
   logic [5:0] hi_req;
   logic use_hi;

   function automatic logic [5:0] dmacs_pick(input logic [5:0] r, input logic [2:0] last);
      logic [5:0] g;
      int idx;
      g = '0;
      for (int k = NUM_CH; k >= 1; k--) begin
         idx = (int'(last) + k) % NUM_CH;
         if (r[idx]) begin
            g = '0;
            g[idx] = 1'b1;
         end
      end
      return g;
   endfunction

   always_comb begin
      nxt_st = st_ff;
      hi_req = link.req & link.high;
      use_hi = |hi_req;
      // high group first, each group rotating from its last winner
      link.grant = use_hi ? dmacs_pick(hi_req, st_ff.last_hi) : dmacs_pick(link.req & ~link.high, st_ff.last_lo);
      for (int i = 0; i < NUM_CH; i++) begin
         if (link.take && link.grant[i]) begin
            if (use_hi) nxt_st.last_hi = 3'(i);
            else nxt_st.last_lo = 3'(i);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) st_ff <= {3'(NUM_CH - 1), 3'(NUM_CH - 1)};
      else st_ff <= nxt_st;
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   property p_grant_legal;
      $onehot0(link.grant) && ((link.grant & ~link.req) == '0) && ((link.req != '0) == (link.grant != '0));
   endproperty
   a_grant_legal: assert property (p_grant_legal) else $error("grant not one of the requests");
   property p_high_first;
      ((link.req & link.high) != '0) |-> ((link.grant & ~link.high) == '0);
   endproperty
   a_high_first: assert property (p_high_first) else $error("low channel beat a high one");
endmodule

// [dmacs_irq_router.sv]
// steers channel 0-3 interrupts onto the lines shared with serial ports
// line order: 0=line 6, 1=line 7, 2=line 10, 3=line 11
`timescale 1ns/1ps
module dmacs_irq_router
   import dmacs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // interrupt sources and routed lines
   dmacs_link_if.rtr link
);
   typedef struct packed {
      logic [3:0] line;
   } dmacs_rtr_st_t;
   dmacs_rtr_st_t st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      unique case (link.route)
         ROUTE_PORTS: nxt_st.line = link.port_irq;
         ROUTE_PART: nxt_st.line = {link.chan_irq[3:2], link.port_irq[1:0]};
         ROUTE_ALL: nxt_st.line = link.chan_irq[3:0];
         default: nxt_st.line = 4'h0;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) st_ff <= '0;
      else st_ff <= nxt_st;
   end
   assign link.line = st_ff.line;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   property p_route_ports;
      (link.route == ROUTE_PORTS) |=> (link.line == $past(link.port_irq));
   endproperty
   a_route_ports: assert property (p_route_ports) else $error("port interrupts not on shared lines");
   property p_route_all;
      (link.route == ROUTE_ALL) |=> (link.line == $past(link.chan_irq[3:0]));
   endproperty
   a_route_all: assert property (p_route_all) else $error("channels 0-3 not on shared lines");
endmodule

// [dmacs_mem_model.sv]
// memory responder for the sequencer's memory port
// assumes the engine holds each request until it sees ack
`timescale 1ns/1ps
module dmacs_mem_model (
   // clock
   input wire logic core_clk_i,
   // memory port
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [15:0] mem_wdata_i,
   output logic mem_ack_o,
   output logic [15:0] mem_rdata_o,
   // write log
   output logic [7:0] wr_cnt_o,
   output logic [15:0] wr_addr_o,
   output logic [15:0] wr_data_o
);
   initial begin
      mem_ack_o = 1'h0;
      mem_rdata_o = 16'h0000;
      wr_cnt_o = 8'h00;
   end
   always @(posedge core_clk_i) begin
      mem_ack_o <= mem_req_i && !mem_ack_o;
      // data is only meaningful with ack, it toggles otherwise
      mem_rdata_o <= (mem_req_i && !mem_ack_o) ? (mem_addr_i ^ 16'ha5a5) : ~mem_rdata_o;
      if (mem_req_i && mem_ack_o && mem_we_i) begin
         wr_cnt_o <= wr_cnt_o + 8'h01;
         wr_addr_o <= mem_addr_i;
         wr_data_o <= mem_wdata_i;
      end
   end
endmodule

// [dma_channel_sequencer_bench.sv]
// bench: apb register checks, two-frame, synchronized auto-reload and doubleword transfers, routing
// assumes a zero-wait apb slave and the memory responder model
`timescale 1ns/1ps
module dma_channel_sequencer_bench;
   import dmacs_pkg::*;
   logic clk, srst, psel, pen, pwr, pready, perr, rerr, mreq, mwe, mack;
   logic p2r, p2t, p1r, p1t, irq6, irq7, irq10, irq11, irq4, irq5;
   logic [15:0] paddr, maddr, mwd, mrd, waddr, wdat;
   logic [31:0] pwdata, prdata, rdat;
   logic [13:0] sync;
   logic [7:0] wcnt;
   int n_errors, checked, n6, n4, n5, i;
   dmacs_top dmacs_top_i (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd),
      .mem_ack_i(mack), .mem_rdata_i(mrd), .sync_evt_i(sync), .port2_receive_irq_i(p2r),
      .port2_transmit_irq_i(p2t), .port1_receive_irq_i(p1r), .port1_transmit_irq_i(p1t),
      .cpu_irq6_o(irq6), .cpu_irq7_o(irq7), .cpu_irq10_o(irq10), .cpu_irq11_o(irq11),
      .channel4_irq_o(irq4), .channel5_irq_o(irq5));
   dmacs_mem_model dmacs_mem_model_i (.core_clk_i(clk), .mem_req_i(mreq), .mem_we_i(mwe),
      .mem_addr_i(maddr), .mem_wdata_i(mwd), .mem_ack_o(mack), .mem_rdata_o(mrd),
      .wr_cnt_o(wcnt), .wr_addr_o(waddr), .wr_data_o(wdat));
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdat = prdata;
      rerr = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic ee);
      apb(1'h0, a, 32'h0);
      chk(rdat, e);
      chk(rerr, ee);
   endtask
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (irq6 === 1'h1) n6 <= n6 + 1;
   always @(posedge clk) if (irq4 === 1'h1) n4 <= n4 + 1;
   always @(posedge clk) if (irq5 === 1'h1) n5 <= n5 + 1;
   // whole run is well under 3000 cycles
   initial begin
      #60000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      {srst, psel, pen, pwr, paddr, pwdata, sync} = {1'h1, 65'h0};
      {p2r, p2t, p1r, p1t, n_errors, checked, n6, n4, n5} = 0;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      rd(OFS_PRIO, {16'h0000, PRIO_RST}, 1'h0);
      rd(16'h0ffc, 32'h0, 1'h1);
      p2r <= 1'h1;
      p1t <= 1'h1;
      repeat (3) @(posedge clk);
      chk(irq6, 1'h1);
      chk(irq11, 1'h1);
      chk(irq7, 1'h0);
      chk(irq10, 1'h0);
      p2r <= 1'h0;
      p1t <= 1'h0;
      wr(OFS_ESTEP0, 32'h2);
      wr(OFS_FSTEP0, 32'h10);
      rd(OFS_FSTEP0, 32'h10, 1'h0);
      wr({10'h001, CH_SRC}, 32'h100);
      wr({10'h001, CH_DST}, 32'h200);
      wr({10'h001, CH_ECNT}, 32'h2);
      wr({10'h001, CH_SYNCF}, 32'h1);
      wr({10'h001, CH_MODE}, 32'h610c);
      n6 = 0;
      wr(OFS_PRIO, 32'h81);
      for (i = 0; i < 500 && wcnt !== 8'h06; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk(wcnt, 8'h06);
      chk(waddr, 16'h0218);
      chk(wdat, 16'ha4a0);
      chk(n6, 2);
      rd(OFS_PRIO, 32'h80, 1'h0);
      // channel 4: synchronized autobuffer with its own reload set
      wr({10'h005, CH_SRC}, 32'h300);
      wr({10'h005, CH_DST}, 32'h400);
      wr({10'h005, CH_ECNT}, 32'h3);
      wr({10'h005, CH_SYNCF}, 32'h1000);
      wr({10'h005, CH_MODE}, 32'hf104);
      wr(OFS_PRIO, 32'h4010);
      repeat (10) @(posedge clk);
      chk(wcnt, 8'h06);
      for (i = 0; i < 8; i++) begin
         if (i == 1) begin
            wr({10'h005, CH_RSRC}, 32'h500);
            wr({10'h005, CH_RDST}, 32'h600);
            wr({10'h005, CH_RECNT}, 32'h1);
            wr({10'h005, CH_RFCNT}, 32'h1);
         end
         sync <= 14'h0001;
         @(posedge clk);
         sync <= 14'h0000;
         repeat (10) @(posedge clk);
         if (i == 3) begin
            chk(wcnt, 8'h0a);
            chk(waddr, 16'h0403);
            chk(wdat, 16'ha6a6);
            chk(n4, 2);
            rd({10'h005, CH_SRC}, 32'h500, 1'h0);
            rd({10'h005, CH_ECNT}, 32'h1, 1'h0);
            rd({10'h005, CH_SYNCF}, 32'h1001, 1'h0);
         end
      end
      chk(wcnt, 8'h0e);
      chk(waddr, 16'h0603);
      chk(wdat, 16'ha0a6);
      chk(n4, 5);
      rd(OFS_PRIO, 32'h4010, 1'h0);
      // channel 5: unsynchronized doubleword, interrupts off
      wr({10'h006, CH_SRC}, 32'h700);
      wr({10'h006, CH_DST}, 32'h800);
      wr({10'h006, CH_ECNT}, 32'h0);
      wr({10'h006, CH_MODE}, 32'h2105);
      wr(OFS_PRIO, 32'h2020);
      for (i = 0; i < 100 && wcnt !== 8'h10; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk(wcnt, 8'h10);
      chk(waddr, 16'h0801);
      chk(wdat, 16'ha2a4);
      chk(n5, 0);
      rd(OFS_PRIO, 32'h2000, 1'h0);
      tally_and_finish();
   end
endmodule
